// ### ssfce_engine.sv
// Functional notes
// - Status query reports live status register
// - Status bits follow live conditions, no latch
// - Reply value is sum of set weights
// - Trigger moves held setpoints to active
// - Held values wait; active stays until trigger
// - Enable accepts comma list of names
// - Enable also accepts summed decimal value
// - Fault bit sets on enabled rising status
// - Unselected conditions cannot set status/fault
// - All/none keywords; reset mask is none
// - Mask query returns enabled weight sum
// - Voltage calibration computes and stores slope/offset
// - Arguments are measured low and high volts
// - High-point command drives calibration voltage
// - High-point voltage at top of range
// - Twelve conditions with power-of-two weights
`include "ssfce_defines.svh"
module ssfce_engine
  import ssfce_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input ssfce_req_t req,
  input wire logic [12:0] condPins,
  input wire logic calibrationSession,
  input wire logic holdMode,
  input ssfce_set_t newSet,
  input wire logic newSetValid,
  output ssfce_rsp_t rsp,
  output logic reqReady,
  output logic [12:0] statusReg,
  output logic [12:0] faultReg,
  output logic [12:0] enableMask,
  output ssfce_set_t activeSet,
  output logic [15:0] calDrive,
  output logic calDriveEn,
  output logic [15:0] calSlope,
  output logic [15:0] calOffset,
  output logic calDone,
  output logic progError
);
  typedef struct packed {
    logic [12:0] syncA;
    logic [12:0] syncB;
    logic [12:0] status;
    logic [12:0] fault;
    logic [12:0] mask;
    ssfce_set_t held;
    ssfce_set_t active;
    ssfce_rsp_t rsp;
    ssfce_state_t state;
    logic divStart;
    logic [15:0] vlo;
    logic [15:0] vhi;
    logic [15:0] calDrive;
    logic calDriveEn;
    logic [15:0] slope;
    logic [15:0] offset;
    logic calDone;
    logic progError;
  } ssfce_eng_st_t;
  ssfce_eng_st_t st_ff;
  ssfce_eng_st_t nxt_st;
  logic divBusy;
  logic [15:0] divQuot;
  logic [12:0] liveCond;
  logic [15:0] span;
  logic [31:0] slopeLo;

  ssfce_divider u_div (
    .core_clk(core_clk),
    .rst(rst),
    .start(st_ff.divStart),
    .num(16'hFFFF),
    .den(span),
    .busy(divBusy),
    .quot(divQuot)
  );

  always_comb
  begin
    liveCond = st_ff.syncB & st_ff.mask;
    liveCond[`SSFCE_BIT_UNUSED] = 1'b0;
    span = (st_ff.vhi > st_ff.vlo) ? (st_ff.vhi - st_ff.vlo) : 16'h0001;
    slopeLo = 32'(divQuot) * 32'(st_ff.vlo);
    nxt_st = st_ff;
    nxt_st.rsp.valid = 1'b0;
    nxt_st.divStart = 1'b0;
    nxt_st.calDone = 1'b0;
    nxt_st.progError = 1'b0;
    nxt_st.syncA = condPins;
    nxt_st.syncB = st_ff.syncA;
    nxt_st.status = liveCond;
    nxt_st.fault = st_ff.fault | (liveCond & ~st_ff.status);
    if (newSetValid)
    begin
      if (holdMode)
        nxt_st.held = newSet;
      else
        nxt_st.active = newSet;
    end
    unique case (st_ff.state)
      ST_IDLE:
      begin
        if (req.valid)
        begin
          unique case (req.code)
            CMD_STATUS_QUERY:
            begin
              nxt_st.rsp = '{valid: 1'b1, isEnable: 1'b0,
                value: st_ff.status};
            end
            CMD_APPLY_HELD:
              nxt_st.active = st_ff.held;
            CMD_ENABLE_NAMES:
            begin
              if (req.nameBad)
                nxt_st.progError = 1'b1;
              else
                nxt_st.mask = st_ff.mask | req.names;
            end
            CMD_ENABLE_VALUE:
              nxt_st.mask = st_ff.mask | req.argA[12:0];
            CMD_ENABLE_ALL:
              nxt_st.mask = `SSFCE_MASK_ALL;
            CMD_ENABLE_NONE:
              nxt_st.mask = `SSFCE_MASK_NONE;
            CMD_ENABLE_QUERY:
            begin
              nxt_st.rsp = '{valid: 1'b1, isEnable: 1'b1,
                value: st_ff.mask};
            end
            CMD_VCAL_HIGH:
            begin
              if (calibrationSession)
              begin
                nxt_st.calDrive = `SSFCE_VHI_CODE;
                nxt_st.calDriveEn = 1'b1;
              end
              else
                nxt_st.progError = 1'b1;
            end
            CMD_VCAL_DATA:
            begin
              if (calibrationSession)
              begin
                nxt_st.vlo = req.argA;
                nxt_st.vhi = req.argB;
                nxt_st.divStart = 1'b1;
                nxt_st.state = ST_DIV;
              end
              else
                nxt_st.progError = 1'b1;
            end
            default:
              nxt_st.progError = 1'b1;
          endcase
        end
      end
      ST_DIV:
      begin
        if (!st_ff.divStart && !divBusy)
          nxt_st.state = ST_DONE;
      end
      ST_DONE:
      begin
        nxt_st.slope = divQuot;
        nxt_st.offset = 16'h0000 - slopeLo[31:16];
        nxt_st.calDone = 1'b1;
        nxt_st.calDriveEn = 1'b0;
        nxt_st.calDrive = `SSFCE_VLO_CODE;
        nxt_st.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (rst)
    begin
      st_ff <= '0;
      st_ff.mask <= `SSFCE_MASK_NONE;
      st_ff.state <= ST_IDLE;
    end
    else
      st_ff <= nxt_st;
  end

  assign reqReady = (st_ff.state == ST_IDLE);
  assign rsp = st_ff.rsp;
  assign statusReg = st_ff.status;
  assign faultReg = st_ff.fault;
  assign enableMask = st_ff.mask;
  assign activeSet = st_ff.active;
  assign calDrive = st_ff.calDrive;
  assign calDriveEn = st_ff.calDriveEn;
  assign calSlope = st_ff.slope;
  assign calOffset = st_ff.offset;
  assign calDone = st_ff.calDone;
  assign progError = st_ff.progError;

  property p_status_follow;
    @(posedge core_clk) disable iff (rst)
    1'b1 |=> statusReg == ($past(st_ff.syncB) & $past(enableMask) &
      13'h1FFB);
  endproperty
  a_status_follow: assert property (p_status_follow)
    else $error("status not following condition");
  property p_fault_set;
    @(posedge core_clk) disable iff (rst)
    (liveCond[0] && !statusReg[0]) |=> faultReg[0];
  endproperty
  a_fault_set: assert property (p_fault_set)
    else $error("fault bit missed rising edge");
  property p_masked;
    @(posedge core_clk) disable iff (rst)
    1'b1 |-> (statusReg & ~st_ff.mask & ~$past(st_ff.mask)) == 13'h0000;
  endproperty
  a_masked: assert property (p_masked)
    else $error("masked condition in status");
  property p_stsq;
    @(posedge core_clk) disable iff (rst)
    (req.valid && reqReady && req.code == CMD_STATUS_QUERY) |=>
      rsp.valid && !rsp.isEnable && rsp.value == $past(statusReg);
  endproperty
  a_stsq: assert property (p_stsq)
    else $error("bad status reply");
  property p_maskq;
    @(posedge core_clk) disable iff (rst)
    (req.valid && reqReady && req.code == CMD_ENABLE_QUERY) |=>
      rsp.valid && rsp.isEnable && rsp.value == $past(enableMask);
  endproperty
  a_maskq: assert property (p_maskq)
    else $error("bad mask reply");
  property p_trig;
    @(posedge core_clk) disable iff (rst)
    (req.valid && reqReady && req.code == CMD_APPLY_HELD && !newSetValid)
      |=> activeSet == $past(st_ff.held);
  endproperty
  a_trig: assert property (p_trig)
    else $error("held set not applied");
  property p_hold;
    @(posedge core_clk) disable iff (rst)
    (holdMode && !(req.valid && reqReady && req.code == CMD_APPLY_HELD))
      |=> $stable(activeSet);
  endproperty
  a_hold: assert property (p_hold)
    else $error("active changed while holding");
  property p_badname;
    @(posedge core_clk) disable iff (rst)
    (req.valid && reqReady && req.code == CMD_ENABLE_NAMES && req.nameBad)
      |=> $stable(enableMask) && progError;
  endproperty
  a_badname: assert property (p_badname)
    else $error("bad name changed mask");
  property p_vhi;
    @(posedge core_clk) disable iff (rst)
    (req.valid && reqReady && req.code == CMD_VCAL_HIGH &&
      calibrationSession) |=> calDriveEn && calDrive == 16'hFFFF;
  endproperty
  a_vhi: assert property (p_vhi)
    else $error("high point not driven");
  property p_cal;
    @(posedge core_clk) disable iff (rst)
    (req.valid && reqReady && req.code == CMD_VCAL_DATA &&
      calibrationSession) |=> ##[1:24] calDone;
  endproperty
  a_cal: assert property (p_cal)
    else $error("calibration never finished");
  c_fault: cover property (@(posedge core_clk) $rose(faultReg[3]));
  c_cal: cover property (@(posedge core_clk) calDone);
  c_trig: cover property (@(posedge core_clk)
    req.valid && req.code == CMD_APPLY_HELD);
endmodule

// ### ssfce_defines.svh
`ifndef SSFCE_DEFINES_SVH
`define SSFCE_DEFINES_SVH
`define SSFCE_NCOND 12
`define SSFCE_MASK_ALL 13'h1FFF
`define SSFCE_MASK_NONE 13'h0000
`define SSFCE_BIT_CONST_VOLT 0
`define SSFCE_BIT_CONST_CURR 1
`define SSFCE_BIT_UNUSED 2
`define SSFCE_BIT_EXCESS_VOLT 3
`define SSFCE_BIT_OVERHEAT 4
`define SSFCE_BIT_EXT_SHUTDOWN 5
`define SSFCE_BIT_BACKOFF 6
`define SSFCE_BIT_ERR 7
`define SSFCE_BIT_POWER_UP 8
`define SSFCE_BIT_HOST_CTRL 9
`define SSFCE_BIT_LINE_LOSS 10
`define SSFCE_BIT_OUT_PROT 11
`define SSFCE_BIT_SENSE_PROT 12
`define SSFCE_VHI_CODE 16'hFFFF
`define SSFCE_VLO_CODE 16'h0000
`define SSFCE_DIV_STEPS 16
`endif

// ### ssfce_pkg.sv
package ssfce_pkg;
  typedef enum logic [7:0] {
    CMD_NONE = 8'h00,
    CMD_STATUS_QUERY = 8'h01,
    CMD_APPLY_HELD = 8'h02,
    CMD_ENABLE_NAMES = 8'h03,
    CMD_ENABLE_VALUE = 8'h04,
    CMD_ENABLE_ALL = 8'h05,
    CMD_ENABLE_NONE = 8'h06,
    CMD_ENABLE_QUERY = 8'h07,
    CMD_VCAL_DATA = 8'h08,
    CMD_VCAL_HIGH = 8'h09
  } ssfce_cmd_t;
  typedef struct packed {
    logic valid;
    ssfce_cmd_t code;
    logic [12:0] names;
    logic nameBad;
    logic [15:0] argA;
    logic [15:0] argB;
  } ssfce_req_t;
  typedef struct packed {
    logic valid;
    logic isEnable;
    logic [12:0] value;
  } ssfce_rsp_t;
  typedef struct packed {
    logic [15:0] volt;
    logic [15:0] curr;
  } ssfce_set_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_DIV = 3'b010,
    ST_DONE = 3'b100
  } ssfce_state_t;
endpackage

// ### ssfce_divider.sv
`include "ssfce_defines.svh"
module ssfce_divider
  import ssfce_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic start,
  input wire logic [15:0] num,
  input wire logic [15:0] den,
  output logic busy,
  output logic [15:0] quot
);
  typedef struct packed {
    logic busy;
    logic [4:0] cnt;
    logic [16:0] remd;
    logic [15:0] q;
    logic [15:0] d;
  } ssfce_div_st_t;
  ssfce_div_st_t st_ff;
  ssfce_div_st_t nxt_st;
  logic [16:0] trial;
  always_comb
  begin
    nxt_st = st_ff;
    trial = {st_ff.remd[15:0], st_ff.q[15]} - {1'b0, st_ff.d};
    if (start && !st_ff.busy)
    begin
      nxt_st.busy = 1'b1;
      nxt_st.cnt = 5'h00;
      nxt_st.remd = 17'h00000;
      nxt_st.q = num;
      nxt_st.d = den;
    end
    else if (st_ff.busy)
    begin
      if (!trial[16])
      begin
        nxt_st.remd = trial;
        nxt_st.q = {st_ff.q[14:0], 1'b1};
      end
      else
      begin
        nxt_st.remd = {st_ff.remd[15:0], st_ff.q[15]};
        nxt_st.q = {st_ff.q[14:0], 1'b0};
      end
      nxt_st.cnt = st_ff.cnt + 5'h01;
      if (st_ff.cnt == 5'(`SSFCE_DIV_STEPS - 1))
        nxt_st.busy = 1'b0;
    end
  end
  always_ff @(posedge core_clk)
  begin
    if (rst)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end
  assign busy = st_ff.busy;
  assign quot = st_ff.q;
endmodule

// ### ssfce_host_model.sv
module ssfce_host_model
  import ssfce_pkg::*;
(
  input wire logic core_clk,
  input wire logic reqReady,
  input ssfce_rsp_t rsp,
  input wire logic progError,
  output ssfce_req_t req,
  output logic calibrationSession
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [12:0] gotValue;
  logic gotRsp;
  logic gotErr;
  initial
  begin
    req = '0;
    calibrationSession = 1'b0;
    gotValue = '0;
    gotRsp = 1'b0;
    gotErr = 1'b0;
  end
  // Session level set before calibration commands
  task automatic session(input logic on);
    @(posedge core_clk);
    #1 calibrationSession = on;
  endtask
  // One request, held until taken, then answer captured
  task automatic send(input ssfce_cmd_t code, input logic [12:0] names,
    input logic bad, input logic [15:0] a, input logic [15:0] b);
    @(posedge core_clk);
    #1;
    req = '{1'b1, code, names, bad, a, b};
    while (reqReady !== 1'b1)
    begin
      @(posedge core_clk);
      #1;
    end
    @(posedge core_clk);
    #1;
    req = '{1'b0, code, ~names, ~bad, ~a, ~b};
    gotRsp = 1'b0;
    gotErr = 1'b0;
    repeat (3)
    begin
      if (rsp.valid === 1'b1)
      begin
        gotRsp = 1'b1;
        gotValue = rsp.value;
      end
      if (progError === 1'b1)
      begin
        gotErr = 1'b1;
      end
      @(posedge core_clk);
      #1;
    end
  endtask
endmodule

// ### ssfce_engine_test.sv
module ssfce_engine_test
  import ssfce_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
`define CHK(got, exp) \
  begin \
    samplesChecked++; \
    if ((got) !== (exp)) \
    begin \
      failCount++; \
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); \
    end \
  end
  logic core_clk, rst, calibrationSession, holdMode, newSetValid;
  logic reqReady, calDriveEn, calDone, progError;
  logic [12:0] condPins, statusReg, faultReg, enableMask;
  logic [15:0] calDrive, calSlope, calOffset;
  ssfce_req_t req;
  ssfce_rsp_t rsp;
  ssfce_set_t newSet, activeSet, oldSet;
  int failCount = 0;
  int samplesChecked = 0;
  ssfce_engine dut (.core_clk(core_clk), .rst(rst), .req(req),
    .condPins(condPins), .calibrationSession(calibrationSession),
    .holdMode(holdMode), .newSet(newSet), .newSetValid(newSetValid),
    .rsp(rsp), .reqReady(reqReady), .statusReg(statusReg),
    .faultReg(faultReg), .enableMask(enableMask), .activeSet(activeSet),
    .calDrive(calDrive), .calDriveEn(calDriveEn), .calSlope(calSlope),
    .calOffset(calOffset), .calDone(calDone), .progError(progError));
  ssfce_host_model host (.core_clk(core_clk), .reqReady(reqReady),
    .rsp(rsp), .progError(progError), .req(req),
    .calibrationSession(calibrationSession));
  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic wait_cycles(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic test_mask();
    `CHK(enableMask, 13'h0000)
    host.send(CMD_ENABLE_NAMES, 13'h0011, 1'b0, 16'h0000, 16'h0000);
    `CHK(enableMask, 13'h0011)
    host.send(CMD_ENABLE_VALUE, 13'h0000, 1'b0, 16'h0300, 16'h0000);
    `CHK(enableMask, 13'h0311)
    host.send(CMD_ENABLE_NAMES, 13'h0800, 1'b1, 16'h0000, 16'h0000);
    `CHK(host.gotErr, 1'b1)
    `CHK(enableMask, 13'h0311)
    host.send(CMD_ENABLE_QUERY, 13'h0000, 1'b0, 16'h0000, 16'h0000);
    `CHK(host.gotValue, 13'h0311)
    host.send(CMD_ENABLE_ALL, 13'h0000, 1'b0, 16'h0000, 16'h0000);
    `CHK(enableMask, 13'h1FFF)
    host.send(CMD_ENABLE_NONE, 13'h0000, 1'b0, 16'h0000, 16'h0000);
    `CHK(enableMask, 13'h0000)
    $display("test_mask done");
  endtask
  task automatic test_status();
    host.send(CMD_ENABLE_VALUE, 13'h0000, 1'b0, 16'h0009, 16'h0000);
    condPins = 13'h0003;
    wait_cycles(6);
    `CHK(statusReg, 13'h0001)
    `CHK(faultReg, 13'h0001)
    condPins = 13'h000B;
    wait_cycles(6);
    `CHK(faultReg, 13'h0009)
    host.send(CMD_STATUS_QUERY, 13'h0000, 1'b0, 16'h0000, 16'h0000);
    `CHK(host.gotRsp, 1'b1)
    `CHK(host.gotValue, 13'h0009)
    host.send(CMD_ENABLE_NAMES, 13'h1000, 1'b0, 16'h0000, 16'h0000);
    condPins = 13'h1004;
    wait_cycles(6);
    `CHK(statusReg, 13'h1000)
    `CHK(faultReg, 13'h1009)
    condPins = 13'h0000;
    wait_cycles(6);
    `CHK(statusReg, 13'h0000)
    $display("test_status done");
  endtask
  task automatic test_hold();
    oldSet = '{16'h1234, 16'h0056};
    newSet = oldSet;
    newSetValid = 1'b1;
    wait_cycles(1);
    newSetValid = 1'b0;
    holdMode = 1'b1;
    newSet = '{16'hABCD, 16'h0077};
    wait_cycles(1);
    newSetValid = 1'b1;
    wait_cycles(1);
    newSetValid = 1'b0;
    wait_cycles(3);
    `CHK(activeSet, oldSet)
    host.send(CMD_APPLY_HELD, 13'h0000, 1'b0, 16'h0000, 16'h0000);
    `CHK(activeSet, newSet)
    holdMode = 1'b0;
    $display("test_hold done");
  endtask
  task automatic test_cal();
    int i;
    host.send(CMD_VCAL_HIGH, 13'h0000, 1'b0, 16'h0000, 16'h0000);
    `CHK(host.gotErr, 1'b1)
    `CHK(calDriveEn, 1'b0)
    host.session(1'b1);
    host.send(CMD_VCAL_HIGH, 13'h0000, 1'b0, 16'h0000, 16'h0000);
    `CHK(calDriveEn, 1'b1)
    `CHK(calDrive, 16'hFFFF)
    // Measured low 1000, high 1100
    host.send(CMD_VCAL_DATA, 13'h0000, 1'b0, 16'h1000, 16'h1100);
    `CHK(reqReady, 1'b0)
    i = 0;
    while (calDone !== 1'b1 && i < 40)
    begin
      wait_cycles(1);
      i++;
    end
    `CHK(calDone, 1'b1)
    `CHK(calSlope, 16'h00FF)
    `CHK(calOffset, 16'hFFF1)
    `CHK(calDriveEn, 1'b0)
    host.session(1'b0);
    $display("test_cal done");
  endtask
  initial
  begin
    rst = 1'b1;
    condPins = 13'h0000;
    holdMode = 1'b0;
    newSet = '0;
    newSetValid = 1'b0;
    oldSet = '0;
    repeat (3) @(posedge core_clk);
    #1 rst = 1'b0;
    test_mask();
    test_status();
    test_hold();
    test_cal();
    report_and_stop();
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    failCount++;
    report_and_stop();
  end
endmodule
